// file: rtl/acs_clock_div.sv
// Purpose: Converter clock enable from the bus clock
// Assumes: One clock domain; enable pulses are one cycle wide
// Notes:   Select 01 halves the bus clock before the divider
`timescale 1ns/1ns
module acs_clock_div
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] inputClockSel,
    input  wire logic [1:0] clockDivSel,
    input  wire logic       altClockTick,
    input  wire logic       asyncClockTick,
    // Output
    output logic            convTick
);
    logic [3:0] divCount_reg;
    logic [3:0] divLimit;
    logic       srcTick;

    always_comb begin
        divLimit = (4'h1 << clockDivSel) - 4'h1;
        if (inputClockSel == 2'h1) begin
            divLimit = {divLimit[2:0], 1'b1};
        end
        case (inputClockSel)
            2'h2:    srcTick = altClockTick;
            2'h3:    srcTick = asyncClockTick;
            default: srcTick = 1'b1;
        endcase
    end

    // Held clear while idle so the first tick of each run comes at a fixed point
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            divCount_reg <= 4'h0;
        end else if (srcTick) begin
            divCount_reg <= (divCount_reg >= divLimit) ? 4'h0 : divCount_reg + 4'h1;
        end
    end

    assign convTick = run && srcTick && (divCount_reg >= divLimit);
endmodule

// file: rtl/acs_consts.svh
// Purpose: Constants for the conversion sequencer
// Assumes: Included by acs_sequencer and the bench
// Notes:   Cycle counts are converter-clock cycles unless named otherwise
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_CLK_MHZ          50
`define ACS_CHAN_OFF         5'h1f
`define ACS_CLKSEL_ASYNC     2'h3
`define ACS_SHORT_SAMPLE     4
`define ACS_LONG_SAMPLE      24
`define ACS_APPROX_8         16
`define ACS_APPROX_10        19
`define ACS_CONT_DELTA       3
`define ACS_BUS_OVERHEAD     5
`define ACS_ASYNC_START_US   5
`define ACS_ASYNC_START_CYC  (`ACS_ASYNC_START_US * `ACS_CLK_MHZ)
`define ACS_RESULT_RESET     10'h000
`endif

// file: rtl/acs_pkg.sv
// Purpose: Types for the conversion sequencer
// Assumes: Nothing
// Notes:   Carrier structs for configuration and register writes
package acs_pkg;
    typedef struct packed {
        logic [1:0] clockDivSel;
        logic       longSampleSel;
        logic       tenBitMode;
        logic [1:0] inputClockSel;
        logic       lowPowerCfg;
    } acs_config_t;

    typedef struct packed {
        logic       ctrlStatusOne;
        logic       ctrlStatusTwo;
        logic       converterConfig;
        logic       compareHigh;
        logic       compareLow;
    } acs_writes_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAKE, ST_OVERHEAD, ST_SAMPLE, ST_APPROX, ST_TRANSFER
    } acs_state_t;
endpackage

// file: rtl/acs_sequencer.sv
// Purpose: Conversion sequencer for a successive-approximation converter
// Assumes: Register writes arrive as one-cycle strobes; analog core supplies rawResult
// Notes:   Result read strobes drive the 10-bit read interlock
`timescale 1ns/1ns
`include "acs_consts.svh"
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int RESULT_WIDTH    = 10,
    parameter int ASYNC_START_CYC = `ACS_ASYNC_START_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Register write strobes and fields
    input  wire acs_writes_t             regWrite,
    input  wire logic [4:0]              channelSelect,
    input  wire logic                    continuousEnable,
    input  wire logic                    completeIrqEnable,
    input  wire logic                    triggerSelect,
    input  wire logic                    compareEnable,
    input  wire logic                    compareGreaterSel,
    input  wire acs_config_t             converterConfig,
    input  wire logic [RESULT_WIDTH-1:0] compareValue,
    // Result register reads
    input  wire logic                    readResultHigh,
    input  wire logic                    readResultLow,
    // System
    input  wire logic                    hwTriggerIn,
    input  wire logic                    stopMode,
    input  wire logic                    altClockTick,
    input  wire logic                    asyncClockTick,
    input  wire logic                    asyncClockReady,
    // Analog core
    input  wire logic [RESULT_WIDTH:0]   rawResult,
    output logic                         sampleActive,
    output logic                         approxActive,
    output logic                         converterEnable,
    output logic                         internalAsyncClock,
    // Status
    output logic [RESULT_WIDTH-1:0]      resultValue,
    output logic                         convCompleteFlag,
    output logic                         conversionActive,
    output logic                         completeIrq
);
    acs_state_t state_reg;
    logic [5:0] phaseCount_reg;
    logic [8:0] wakeCount_reg;
    logic       contRun_reg;
    logic       firstConv_reg;
    logic       trigPrev_reg;
    logic       readLock_reg;
    logic       convTick;
    logic       trigEdge;
    logic       startReq;
    logic       abortReq;
    logic       running;
    logic       compareTrue;
    logic       blocked;
    logic       transferOk;
    logic       channelOff;
    logic [RESULT_WIDTH-1:0] rounded;
    logic [RESULT_WIDTH:0]   diff;
    logic [5:0] approxLen;
    logic [5:0] sampleLen;

    assign channelOff = (channelSelect == `ACS_CHAN_OFF);
    assign trigEdge   = hwTriggerIn && !trigPrev_reg;
    assign running    = (state_reg != ST_IDLE);

    // Stop only aborts when the internal clock is not the conversion clock
    assign abortReq = regWrite.ctrlStatusOne || regWrite.ctrlStatusTwo
                   || regWrite.converterConfig || regWrite.compareHigh
                   || regWrite.compareLow
                   || (stopMode && converterConfig.inputClockSel != `ACS_CLKSEL_ASYNC);

    // Edges while busy are dropped, even in continuous mode
    assign startReq = !channelOff && !stopMode
                   && ((regWrite.ctrlStatusOne && !triggerSelect)
                   || (triggerSelect && trigEdge && !running && !abortReq));

    // Round off the one extra raw bit in 10-bit mode and three in 8-bit mode, which sits in the low bits
    always_comb begin
        rounded = '0;
        if (converterConfig.tenBitMode) begin
            rounded = (rawResult[RESULT_WIDTH:1] == '1) ? rawResult[RESULT_WIDTH:1]
                    : rawResult[RESULT_WIDTH:1] + RESULT_WIDTH'(rawResult[0]);
        end else begin
            rounded[7:0] = (rawResult[RESULT_WIDTH:3] == 8'hff) ? 8'hff
                         : rawResult[RESULT_WIDTH:3] + 8'(rawResult[2]);
        end
    end

    // Subtraction is one bit wider; top bit is the sign
    assign diff = {1'b0, rounded} - {1'b0, compareValue};
    assign compareTrue = !compareEnable || (compareGreaterSel ? !diff[RESULT_WIDTH]
                                                              : diff[RESULT_WIDTH]);
    assign blocked    = converterConfig.tenBitMode && readLock_reg;
    assign transferOk = (state_reg == ST_TRANSFER) && compareTrue && !blocked;

    assign approxLen = converterConfig.tenBitMode ? 6'(`ACS_APPROX_10) : 6'(`ACS_APPROX_8);
    assign sampleLen = converterConfig.longSampleSel ? 6'(`ACS_LONG_SAMPLE)
                                                     : 6'(`ACS_SHORT_SAMPLE);

    acs_clock_div u_div (
        .clk            (clk),
        .rst_n          (rst_n),
        .run            (running),
        .inputClockSel  (converterConfig.inputClockSel),
        .clockDivSel    (converterConfig.clockDivSel),
        .altClockTick   (altClockTick),
        .asyncClockTick (asyncClockTick),
        .convTick       (convTick)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trigPrev_reg <= 1'b0;
        end else begin
            trigPrev_reg <= hwTriggerIn;
        end
    end

    // Read lock: high byte read opens, low byte read closes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readLock_reg <= 1'b0;
        end else if (readResultLow) begin
            readLock_reg <= 1'b0;
        end else if (readResultHigh) begin
            readLock_reg <= 1'b1;
        end
    end

    // Sequencer: idle, optional wake, bus overhead, sample, approximation, transfer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            phaseCount_reg <= 6'h00;
            wakeCount_reg  <= 9'h000;
            contRun_reg    <= 1'b0;
            firstConv_reg  <= 1'b0;
        end else if (startReq) begin
            state_reg      <= (converterConfig.inputClockSel == `ACS_CLKSEL_ASYNC)
                              ? ST_WAKE : ST_OVERHEAD;
            phaseCount_reg <= 6'h00;
            wakeCount_reg  <= 9'h000;
            contRun_reg    <= continuousEnable;
            firstConv_reg  <= 1'b1;
        end else if (abortReq || channelOff) begin
            state_reg   <= ST_IDLE;
            contRun_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    phaseCount_reg <= 6'h00;
                end
                ST_WAKE: begin
                    wakeCount_reg <= wakeCount_reg + 9'h001;
                    if (asyncClockReady || wakeCount_reg >= 9'(ASYNC_START_CYC - 1)) begin
                        state_reg <= ST_OVERHEAD;
                    end
                end
                ST_OVERHEAD: begin
                    phaseCount_reg <= phaseCount_reg + 6'h01;
                    if (phaseCount_reg == 6'(`ACS_BUS_OVERHEAD - 2)) begin
                        state_reg      <= ST_SAMPLE;
                        phaseCount_reg <= 6'h00;
                    end
                end
                ST_SAMPLE: begin
                    if (convTick) begin
                        phaseCount_reg <= phaseCount_reg + 6'h01;
                        if (phaseCount_reg == sampleLen - 6'h01) begin
                            state_reg      <= ST_APPROX;
                            phaseCount_reg <= 6'h00;
                        end
                    end
                end
                ST_APPROX: begin
                    if (convTick) begin
                        phaseCount_reg <= phaseCount_reg + 6'h01;
                        if (phaseCount_reg == approxLen - 6'h01) begin
                            state_reg <= ST_TRANSFER;
                        end
                    end
                end
                ST_TRANSFER: begin
                    phaseCount_reg <= 6'h00;
                    firstConv_reg  <= 1'b0;
                    if (blocked && !(compareEnable && !compareTrue && !contRun_reg)) begin
                        state_reg <= ST_SAMPLE;
                    end else if (contRun_reg) begin
                        // Later conversions skip the overhead and part of sampling
                        state_reg      <= ST_SAMPLE;
                        phaseCount_reg <= 6'(`ACS_CONT_DELTA);
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Results survive aborts; only reset restores them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultValue <= `ACS_RESULT_RESET;
        end else if (transferOk) begin
            resultValue <= compareEnable ? diff[RESULT_WIDTH-1:0] : rounded;
        end
    end

    // Flag: a new transfer wins over the clear by a first-register write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            convCompleteFlag <= 1'b0;
        end else if (transferOk) begin
            convCompleteFlag <= 1'b1;
        end else if (regWrite.ctrlStatusOne || readResultLow) begin
            convCompleteFlag <= 1'b0;
        end
    end

    assign completeIrq        = convCompleteFlag && completeIrqEnable;
    assign conversionActive   = running;
    assign converterEnable    = running && !channelOff;
    assign sampleActive       = (state_reg == ST_SAMPLE);
    assign approxActive       = (state_reg == ST_APPROX);
    assign internalAsyncClock = running
                             && converterConfig.inputClockSel == `ACS_CLKSEL_ASYNC;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    start_sw_a: assert property (regWrite.ctrlStatusOne && !triggerSelect && !channelOff
        && !stopMode |=> running) else $error("software write did not start");
    start_hw_a: assert property (triggerSelect && trigEdge && !running && !abortReq
        && !channelOff && !stopMode |=> running) else $error("trigger not taken");
    busy_edge_a: assert property (running && triggerSelect && !regWrite.ctrlStatusOne
        && !abortReq && trigEdge |=> $stable(firstConv_reg) || state_reg != ST_WAKE)
        else $error("busy edge restarted");
    flag_set_a: assert property (transferOk |=> convCompleteFlag)
        else $error("flag missing after transfer");
    block_keep_a: assert property (state_reg == ST_TRANSFER && blocked
        |=> $stable(resultValue)) else $error("blocked result written");
    cmp_false_a: assert property (state_reg == ST_TRANSFER && compareEnable && !compareTrue
        |=> $stable(resultValue)) else $error("false compare wrote result");
    abort_idle_a: assert property (regWrite.ctrlStatusTwo && !startReq |=> !running)
        else $error("abort left converter busy");
    abort_keep_a: assert property (abortReq && !transferOk |=> $stable(resultValue))
        else $error("abort altered result");
    async_idle_a: assert property (!running |-> !internalAsyncClock)
        else $error("async clock on while idle");
    cont_go_a: assert property (state_reg == ST_TRANSFER && contRun_reg && !abortReq
        && !channelOff && !startReq |=> state_reg == ST_SAMPLE)
        else $error("continuous did not relaunch");
    irq_gate_a: assert property (completeIrq |-> completeIrqEnable && convCompleteFlag)
        else $error("irq without flag");

    single_c: cover property (state_reg == ST_TRANSFER && !contRun_reg ##1 !running);
    cont_c: cover property (state_reg == ST_TRANSFER && contRun_reg ##1 sampleActive);
    block_c: cover property (state_reg == ST_TRANSFER && blocked);
    cmp_c: cover property (transferOk && compareEnable);
endmodule

// file: test/acs_analog_model.sv
// Purpose: Analog core stand-in that hands the sequencer a raw code
// Assumes: Bench sets the level to be converted
// Notes:   Outside a conversion the code toggles, so a stale value cannot pass
`timescale 1ns/1ns
module acs_analog_model (
    // Clock
    input  wire logic        clk,
    // Sequencer side
    input  wire logic        converterEnable,
    input  wire logic [10:0] analogLevel,
    // Raw code
    output logic      [10:0] rawResult
);
    logic [10:0] junkReg = 11'h555;

    always_ff @(posedge clk) begin
        junkReg <= ~junkReg;
    end

    // Input held steady only while the converter runs
    assign rawResult = converterEnable ? analogLevel : junkReg;
endmodule

// file: test/adc_conversion_sequencer_bench.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Inputs change at the falling edge; bus clock is the converter clock
// Notes:   Wake count shortened to 4 cycles to keep the run brief
`timescale 1ns/1ns
`include "acs_consts.svh"
module adc_conversion_sequencer_bench
    import acs_pkg::*;
;
    localparam acs_writes_t W_ONE = 5'h10, W_TWO = 5'h08, W_CFG = 5'h04;
    localparam acs_writes_t W_CMPH = 5'h02, W_CMPL = 5'h01;
    logic clk, rst_n, continuousEnable, completeIrqEnable, triggerSelect;
    logic compareEnable, compareGreaterSel, readResultHigh, readResultLow;
    logic hwTriggerIn, stopMode, sampleActive, approxActive, converterEnable;
    logic internalAsyncClock, convCompleteFlag, conversionActive, completeIrq;
    acs_writes_t regWrite;
    acs_config_t converterConfig;
    logic [4:0]  channelSelect;
    logic [9:0]  compareValue, resultValue;
    logic [10:0] rawResult, analogLevel;
    int          badCount, checkCount, cycles, n;
    acs_writes_t aborts [4] = '{W_TWO, W_CFG, W_CMPH, W_CMPL};

    acs_sequencer #(.ASYNC_START_CYC(4)) u_acs_sequencer (
        .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .channelSelect(channelSelect),
        .continuousEnable(continuousEnable), .completeIrqEnable(completeIrqEnable),
        .triggerSelect(triggerSelect), .compareEnable(compareEnable),
        .compareGreaterSel(compareGreaterSel), .converterConfig(converterConfig),
        .compareValue(compareValue), .readResultHigh(readResultHigh),
        .readResultLow(readResultLow), .hwTriggerIn(hwTriggerIn), .stopMode(stopMode),
        .altClockTick(1'b1), .asyncClockTick(1'b1), .asyncClockReady(1'b0),
        .rawResult(rawResult), .sampleActive(sampleActive), .approxActive(approxActive),
        .converterEnable(converterEnable), .internalAsyncClock(internalAsyncClock),
        .resultValue(resultValue), .convCompleteFlag(convCompleteFlag),
        .conversionActive(conversionActive), .completeIrq(completeIrq));
    acs_analog_model u_acs_analog_model (.clk(clk), .converterEnable(converterEnable),
        .analogLevel(analogLevel), .rawResult(rawResult));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            badCount++;
            $display("wrong value run length expected finish seen timeout");
            test_done();
        end
    end

    task automatic check_word(input string what, input logic [9:0] exp, input logic [9:0] got);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Overhead, sample, approximation, then one transfer edge that raises the flag
    function automatic int first_time(input logic ten, input logic lng);
        return (`ACS_BUS_OVERHEAD - 1) + (lng ? `ACS_LONG_SAMPLE : `ACS_SHORT_SAMPLE)
            + (ten ? `ACS_APPROX_10 : `ACS_APPROX_8) + 1;
    endfunction
    task automatic strobe(input acs_writes_t w);
        @(negedge clk);
        regWrite = w;
        @(negedge clk);
        regWrite = '0;
    endtask
    // Reads happen only when no single conversion runs, apart from the interlock
    task automatic read_res(input logic high);
        @(negedge clk);
        readResultHigh = high;
        readResultLow  = !high;
        @(negedge clk);
        readResultHigh = 1'b0;
        readResultLow  = 1'b0;
    endtask
    task automatic trig;
        @(negedge clk);
        hwTriggerIn = 1'b1;
        @(negedge clk);
        hwTriggerIn = 1'b0;
    endtask
    task automatic wait_done(input int limit, output int k);
        k = 0;
        while (convCompleteFlag !== 1'b1 && k < limit) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic setup(input logic ten, input logic lng, input logic [1:0] sel,
                         input logic [10:0] level);
        converterConfig = '{2'h0, lng, ten, sel, 1'b0};
        analogLevel = level;
        strobe(W_CFG);
    endtask

    initial begin
        rst_n = 1'b0; regWrite = '0; channelSelect = 5'h01; continuousEnable = 1'b0;
        completeIrqEnable = 1'b1; triggerSelect = 1'b0; compareEnable = 1'b0;
        compareGreaterSel = 1'b0; converterConfig = '0; compareValue = 10'h000;
        readResultHigh = 1'b0; readResultLow = 1'b0; hwTriggerIn = 1'b0;
        stopMode = 1'b0; analogLevel = 11'h000; badCount = 0; checkCount = 0; cycles = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check_word("reset result", 10'h000, resultValue);
        check_bit("reset active", 1'b0, conversionActive);
        for (int i = 0; i < 4; i++) begin
            setup(i[0], i[1], 2'h0, 11'h7FF);
            strobe(W_ONE);
            wait_done(80, n);
            check_word("conversion cycles", 10'(first_time(i[0], i[1])), 10'(n));
            check_word("saturated result", i[0] ? 10'h3FF : 10'h0FF, resultValue);
            check_bit("irq follows flag", 1'b1, completeIrq);
        end
        setup(1'b1, 1'b0, 2'h0, 11'h2A5);
        strobe(W_ONE);
        idle_then_restart();
        check_word("restart cycles", 10'(first_time(1, 0)), 10'(n));
        check_word("rounded result", 10'h153, resultValue);
        channelSelect = 5'h1F;
        strobe(W_ONE);
        repeat (3) @(negedge clk);
        check_bit("channel off", 1'b0, converterEnable);
        channelSelect = 5'h01;
        analogLevel = 11'h001;
        for (int i = 0; i < 5; i++) begin
            strobe(W_ONE);
            repeat (10) @(negedge clk);
            check_bit("approx phase", 1'b1, approxActive);
            if (i < 4) strobe(aborts[i]);
            else stopMode = 1'b1;
            repeat (2) @(negedge clk);
            check_bit("active after abort", 1'b0, conversionActive);
            stopMode = 1'b0;
            wait_done(60, n);
            check_bit("flag after abort", 1'b0, convCompleteFlag);
            check_word("result kept", 10'h153, resultValue);
        end
        analogLevel = 11'h0FF;
        compareValue = 10'h200;
        compareEnable = 1'b1;
        strobe(W_TWO);
        strobe(W_ONE);
        wait_done(80, n);
        check_bit("below limit flag", 1'b1, convCompleteFlag);
        check_word("difference stored", 10'h280, resultValue);
        compareGreaterSel = 1'b1;
        strobe(W_TWO);
        read_res(1'b1);
        strobe(W_ONE);
        wait_done(first_time(1, 0) + 5, n);
        check_bit("false compare flag", 1'b0, convCompleteFlag);
        check_word("false compare result", 10'h280, resultValue);
        check_bit("blocked false stops", 1'b0, conversionActive);
        read_res(1'b0);
        analogLevel = 11'h5FF;
        strobe(W_ONE);
        wait_done(80, n);
        check_word("upper difference", 10'h100, resultValue);
        compareEnable = 1'b0;
        strobe(W_TWO);
        analogLevel = 11'h2A5;
        read_res(1'b1);
        strobe(W_ONE);
        wait_done(first_time(1, 0) + 2, n);
        check_bit("blocked flag", 1'b0, convCompleteFlag);
        check_word("blocked result", 10'h100, resultValue);
        check_bit("blocked restarts", 1'b1, conversionActive);
        read_res(1'b0);
        wait_done(80, n);
        check_word("after unblock", 10'h153, resultValue);
        triggerSelect = 1'b1;
        strobe(W_TWO);
        read_res(1'b0);
        analogLevel = 11'h0FF;
        trig();
        repeat (5) @(negedge clk);
        trig();
        wait_done(80, n);
        check_word("trigger cycles", 10'(first_time(1, 0)), 10'(n + 7));
        check_word("trigger result", 10'h080, resultValue);
        triggerSelect = 1'b0;
        continuousEnable = 1'b1;
        setup(1'b0, 1'b0, 2'h0, 11'h0FF);
        strobe(W_ONE);
        wait_done(80, n);
        check_word("first continuous", 10'(first_time(0, 0)), 10'(n));
        read_res(1'b0);
        check_bit("flag cleared", 1'b0, convCompleteFlag);
        wait_done(40, n);
        check_bit("relaunch bound", 1'b1, convCompleteFlag && (n + 2) <= 18);
        strobe(W_TWO);
        check_bit("continuous aborted", 1'b0, conversionActive);
        continuousEnable = 1'b0;
        setup(1'b0, 1'b0, 2'h3, 11'h0FF);
        check_bit("async idle off", 1'b0, internalAsyncClock);
        strobe(W_ONE);
        stopMode = 1'b1;
        @(negedge clk);
        check_bit("async on", 1'b1, internalAsyncClock);
        wait_done(first_time(0, 0) + 8, n);
        check_bit("async done in stop", 1'b1, convCompleteFlag);
        stopMode = 1'b0;
        @(negedge clk);
        check_bit("async off again", 1'b0, internalAsyncClock);
        setup(1'b0, 1'b0, 2'h0, 11'h0FF);
        strobe(W_ONE);
        repeat (5) @(negedge clk);
        check_bit("sample phase", 1'b1, sampleActive);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check_word("reset abort result", 10'h000, resultValue);
        check_bit("reset abort active", 1'b0, conversionActive);
        rst_n = 1'b1;
        test_done();
    end

    // Second write mid-run must restart the full count
    task automatic idle_then_restart;
        repeat (10) @(negedge clk);
        strobe(W_ONE);
        wait_done(80, n);
    endtask
endmodule
